// ### src/s16t_pkg.sv
// Constants, register map and helpers for the sixteen-bit timer
package s16t_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_GLOBAL_INT = 8'h0B;
  localparam logic [7:0] IDX_INT_FLAGS = 8'h0C;
  localparam logic [7:0] IDX_COUNT_LOW = 8'h0E;
  localparam logic [7:0] IDX_COUNT_HIGH = 8'h0F;
  localparam logic [7:0] IDX_TIMER_CONTROL = 8'h10;
  localparam logic [7:0] IDX_INT_ENABLES = 8'h8C;
  localparam int ADR_IDX_LSB = 2;
  localparam int ADR_IDX_MSB = 9;
  // timer_control fields
  localparam int CTL_TIMER_ON = 0;
  localparam int CTL_CLOCK_SOURCE = 1;
  localparam int CTL_SYNC_BAR = 2;
  localparam int CTL_OSC_ENABLE = 3;
  localparam int CTL_PRESCALE_LSB = 4;
  localparam int CTL_PRESCALE_MSB = 5;
  localparam logic [7:0] CTL_MASK = 8'h3F;
  localparam logic [7:0] CTL_RESET = 8'h00;
  // Interrupt bits
  localparam int FLAG_OVERFLOW = 0;
  localparam int ENABLE_OVERFLOW = 0;
  localparam int GIC_GLOBAL = 7;
  localparam int GIC_PERIPHERAL = 6;
  // Counting
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [3:0] MODE_SPECIAL_EVENT = 4'hB;
  localparam logic [1:0] INSTR_LAST = 2'h3;
  localparam logic [1:0] INSTR_STEP = 2'h1;
  localparam logic [2:0] PS_STEP = 3'h1;
  localparam logic [2:0] PS_ZERO = 3'h0;
  localparam int CLK_HZ = 100_000_000;
  localparam int OSC_MAX_HZ = 200_000;

  // Prescale mask: counter wraps when all masked bits are set
  function automatic logic [2:0] ps_mask(input logic [1:0] sel);
    case (sel)
      2'h0: ps_mask = 3'h0;
      2'h1: ps_mask = 3'h1;
      2'h2: ps_mask = 3'h3;
      default: ps_mask = 3'h7;
    endcase
  endfunction : ps_mask
endpackage : s16t_pkg

// ### src/s16t_prescale.sv
// Input prescaler for the sixteen-bit timer
`timescale 1ns/1ps
module s16t_prescale (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ev_i,
  input wire logic [1:0] sel_i,
  output logic tick_o
);
  logic [2:0] cnt_q;
  logic last;

  assign last = (cnt_q & s16t_pkg::ps_mask(sel_i)) == s16t_pkg::ps_mask(sel_i);

  // ==========================================================
  // Divide by 1, 2, 4 or 8
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= s16t_pkg::PS_ZERO;
      tick_o <= 1'b0;
    end else begin
      tick_o <= ev_i & last;
      if (ev_i) begin
        cnt_q <= last ? s16t_pkg::PS_ZERO : cnt_q + s16t_pkg::PS_STEP;
      end
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_div_by_one: assert property (ev_i && sel_i == 2'h0 |=> tick_o) else $error("1:1 prescale missed a tick");
  a_div_spacing: assert property (tick_o && sel_i == 2'h3 && $stable(sel_i) |=> !tick_o) else $error("1:8 ticks too close");
endmodule : s16t_prescale

// ### src/s16t_timer.sv
// Sixteen-bit timer/counter with oscillator pin control and Wishbone registers
// Contract
// - Oscillator enabled only while control bit 3 set
// - Oscillator enabled releases both shared pins
// - Oscillator up to 200 kHz, runs in sleep
// - Count runs 0000h to FFFFh then wraps
// - Wrap sets latched overflow flag, flag bit 0
// - Flag raises interrupt only when enable bit set
// - Compare mode 1011 match clears count, starts conversion
// - Special event reset never sets overflow flag
// - Special event reset blocked in unsynchronized mode
// - Count write beats coincident special event reset
// - Compare pair acts as timer period
// - Power-on reset clears control, count, overflow flag and interrupt enables
// - Instruction cycle or external rising edge counting
// - Counting only while timer on bit set
// - Prescale field divides by 1, 2, 4, 8
`timescale 1ns/1ps
module s16t_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic shared_port_pin_zero_i,
  input wire logic osc_clk_i,
  input wire logic [1:0] port_out_i,
  input wire logic [1:0] port_direction_bits_i,
  input wire logic sleep_i,
  input wire logic [3:0] compare_mode_field_i,
  input wire logic [15:0] compare_register_pair_i,
  input wire logic adc_enable_i,
  output logic [1:0] shared_port_pin_o,
  output logic [1:0] shared_port_pin_oe_o,
  output logic osc_enable_bit_o,
  output logic irq_o,
  output logic special_event_o,
  output logic adc_start_o
);
  // ==========================================================
  // Register bus
  logic req;
  logic [7:0] idx;
  logic wr;
  logic wr_low;
  logic wr_high;
  logic wr_flags;
  logic wr_ctl;
  logic wr_ie;
  logic wr_gic;
  logic [7:0] rd_byte;
  logic [7:0] ctl_q;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic overflow_flag_q;
  logic overflow_interrupt_enable_q;
  logic global_interrupt_enable_q;
  logic peripheral_interrupt_gate_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = a == b;
  endfunction : hit

  assign req = cyc_i & stb_i;
  assign idx = adr_i[s16t_pkg::ADR_IDX_MSB:s16t_pkg::ADR_IDX_LSB];
  assign wr = req & we_i & ack_o & sel_i[0];
  assign wr_low = wr & hit(idx, s16t_pkg::IDX_COUNT_LOW);
  assign wr_high = wr & hit(idx, s16t_pkg::IDX_COUNT_HIGH);
  assign wr_flags = wr & hit(idx, s16t_pkg::IDX_INT_FLAGS);
  assign wr_ctl = wr & hit(idx, s16t_pkg::IDX_TIMER_CONTROL);
  assign wr_ie = wr & hit(idx, s16t_pkg::IDX_INT_ENABLES);
  assign wr_gic = wr & hit(idx, s16t_pkg::IDX_GLOBAL_INT);

  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      s16t_pkg::IDX_GLOBAL_INT: begin
        rd_byte[s16t_pkg::GIC_GLOBAL] = global_interrupt_enable_q;
        rd_byte[s16t_pkg::GIC_PERIPHERAL] = peripheral_interrupt_gate_q;
      end
      s16t_pkg::IDX_INT_FLAGS: rd_byte[s16t_pkg::FLAG_OVERFLOW] = overflow_flag_q;
      s16t_pkg::IDX_COUNT_LOW: rd_byte = count_q[7:0];
      s16t_pkg::IDX_COUNT_HIGH: rd_byte = count_q[15:8];
      s16t_pkg::IDX_TIMER_CONTROL: rd_byte = ctl_q & s16t_pkg::CTL_MASK;
      s16t_pkg::IDX_INT_ENABLES: rd_byte[s16t_pkg::ENABLE_OVERFLOW] = overflow_interrupt_enable_q;
      default: rd_byte = 8'h00;
    endcase
  end

  // Ack one cycle after the request; every address answers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req & ~ack_o;
      if (req & ~ack_o) begin
        dat_o <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ==========================================================
  // Control and enable registers
  logic timer_on;
  logic clock_source_select;
  logic external_sync_bar;
  logic [1:0] prescale_select;
  logic unsync_mode;

  assign timer_on = ctl_q[s16t_pkg::CTL_TIMER_ON];
  assign clock_source_select = ctl_q[s16t_pkg::CTL_CLOCK_SOURCE];
  assign external_sync_bar = ctl_q[s16t_pkg::CTL_SYNC_BAR];
  assign prescale_select = ctl_q[s16t_pkg::CTL_PRESCALE_MSB:s16t_pkg::CTL_PRESCALE_LSB];
  assign unsync_mode = clock_source_select & external_sync_bar;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= s16t_pkg::CTL_RESET;
    end else if (wr_ctl) begin
      ctl_q <= dat_i[7:0] & s16t_pkg::CTL_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overflow_interrupt_enable_q <= 1'b0;
      global_interrupt_enable_q <= 1'b0;
      peripheral_interrupt_gate_q <= 1'b0;
    end else begin
      if (wr_ie) begin
        overflow_interrupt_enable_q <= dat_i[s16t_pkg::ENABLE_OVERFLOW];
      end
      if (wr_gic) begin
        global_interrupt_enable_q <= dat_i[s16t_pkg::GIC_GLOBAL];
        peripheral_interrupt_gate_q <= dat_i[s16t_pkg::GIC_PERIPHERAL];
      end
    end
  end

  // ==========================================================
  // Oscillator and shared pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_enable_bit_o <= 1'b0;
      shared_port_pin_o <= 2'h0;
      shared_port_pin_oe_o <= 2'h0;
    end else begin
      // Sleep does not gate the oscillator
      osc_enable_bit_o <= ctl_q[s16t_pkg::CTL_OSC_ENABLE];
      shared_port_pin_o <= port_out_i;
      shared_port_pin_oe_o <= ctl_q[s16t_pkg::CTL_OSC_ENABLE] ? 2'h0 : ~port_direction_bits_i;
    end
  end

  // ==========================================================
  // Clock sources
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic ext_prev_q;
  logic ext_level;
  logic ext_rise;
  logic [1:0] instr_cnt_q;
  logic instr_tick;
  logic run;
  logic src_ev;
  logic ps_tick;
  logic ps_tick_rs_q;
  logic inc;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
      ext_prev_q <= 1'b0;
      instr_cnt_q <= 2'h0;
      ps_tick_rs_q <= 1'b0;
    end else begin
      sync1_q <= {osc_clk_i, shared_port_pin_zero_i};
      sync2_q <= sync1_q;
      ext_prev_q <= ext_level;
      instr_cnt_q <= (instr_cnt_q == s16t_pkg::INSTR_LAST) ? 2'h0 : instr_cnt_q + s16t_pkg::INSTR_STEP;
      ps_tick_rs_q <= ps_tick;
    end
  end

  // Oscillator output replaces the pin as the external clock
  assign ext_level = ctl_q[s16t_pkg::CTL_OSC_ENABLE] ? sync2_q[1] : sync2_q[0];
  assign ext_rise = ext_level & ~ext_prev_q;
  assign instr_tick = instr_cnt_q == s16t_pkg::INSTR_LAST;
  // Only the unsynchronized counter keeps counting during sleep
  assign run = timer_on & (~sleep_i | unsync_mode);
  assign src_ev = run & (clock_source_select ? ext_rise : instr_tick);

  s16t_prescale u_prescale (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ev_i(src_ev),
    .sel_i(prescale_select),
    .tick_o(ps_tick)
  );

  // Synchronized counter takes the resampled tick
  assign inc = timer_on & ((clock_source_select & ~external_sync_bar) ? ps_tick_rs_q : ps_tick);

  // ==========================================================
  // Compare special event
  logic match_now;
  logic match_q;
  logic spec_ev;
  logic count_wr;
  logic spec_apply;
  logic overflow;

  assign match_now = (compare_mode_field_i == s16t_pkg::MODE_SPECIAL_EVENT)
                     & (count_q == compare_register_pair_i);
  assign spec_ev = match_now & ~match_q;
  assign count_wr = wr_low | wr_high;
  assign spec_apply = spec_ev & ~unsync_mode & ~count_wr;
  assign overflow = inc & (count_q == s16t_pkg::COUNT_MAX) & ~spec_apply & ~count_wr;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_q <= 1'b0;
      special_event_o <= 1'b0;
      adc_start_o <= 1'b0;
    end else begin
      match_q <= match_now;
      special_event_o <= spec_ev;
      adc_start_o <= spec_ev & adc_enable_i;
    end
  end

  // ==========================================================
  // Count and overflow flag
  always_comb begin
    count_d = count_q;
    if (inc) begin
      count_d = count_q + s16t_pkg::COUNT_ONE;
    end
    if (spec_apply) begin
      count_d = s16t_pkg::COUNT_ZERO;
    end
    if (wr_low) begin
      count_d[7:0] = dat_i[7:0];
    end
    if (wr_high) begin
      count_d[15:8] = dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= s16t_pkg::COUNT_ZERO;
    end else begin
      count_q <= count_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overflow_flag_q <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      // Hardware set wins over a software clear
      overflow_flag_q <= overflow | (wr_flags ? dat_i[s16t_pkg::FLAG_OVERFLOW] : overflow_flag_q);
      irq_o <= overflow_flag_q & overflow_interrupt_enable_q
               & global_interrupt_enable_q & peripheral_interrupt_gate_q;
    end
  end

  // ==========================================================
  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held two cycles");
  a_count_step: assert property (inc && !spec_apply && !count_wr && count_q != s16t_pkg::COUNT_MAX
    |=> count_q == $past(count_q) + s16t_pkg::COUNT_ONE) else $error("count did not step");
  a_wrap_flag: assert property (overflow |=> count_q == s16t_pkg::COUNT_ZERO && overflow_flag_q)
    else $error("wrap without flag");
  a_flag_latched: assert property (overflow_flag_q && !wr_flags |=> overflow_flag_q) else $error("flag lost");
  a_irq_gate: assert property (overflow_flag_q && !overflow_interrupt_enable_q |=> !irq_o)
    else $error("irq without enable");
  a_irq_raise: assert property (overflow_flag_q && overflow_interrupt_enable_q && global_interrupt_enable_q
    && peripheral_interrupt_gate_q |=> irq_o) else $error("irq missing");
  a_spec_clear: assert property (spec_ev && !unsync_mode && !count_wr
    |=> count_q == s16t_pkg::COUNT_ZERO ##0 special_event_o) else $error("special event kept count");
  a_spec_noflag: assert property (spec_apply && !overflow_flag_q && !wr_flags |=> !overflow_flag_q)
    else $error("special event set flag");
  a_unsync_keep: assert property (spec_ev && unsync_mode && !count_wr && !inc |=> count_q == $past(count_q))
    else $error("reset in unsynchronized mode");
  a_write_wins: assert property (wr_low && spec_ev |=> count_q[7:0] == $past(dat_i[7:0]))
    else $error("write lost to special event");
  a_osc_follow: assert property (osc_enable_bit_o == $past(ctl_q[s16t_pkg::CTL_OSC_ENABLE]))
    else $error("oscillator enable wrong");
  a_pins_free: assert property (ctl_q[s16t_pkg::CTL_OSC_ENABLE] |=> shared_port_pin_oe_o == 2'h0)
    else $error("pins driven with oscillator on");
  a_stop_off: assert property (!timer_on && !count_wr && !spec_apply |=> $stable(count_q))
    else $error("count moved while off");
  a_instr_rate: assert property (instr_tick |=> !instr_tick [*3] ##1 instr_tick) else $error("bad instruction rate");
  a_ctl_reset: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=> ctl_q == s16t_pkg::CTL_RESET)
    else $error("control not cleared");

  c_overflow: cover property (overflow ##[1:4] irq_o);
  c_special: cover property (spec_apply ##1 adc_start_o);
  c_collide: cover property (wr_low && spec_ev);
  c_sleep_count: cover property (sleep_i && unsync_mode && inc);
endmodule : s16t_timer

// ### sim/s16t_osc_model.sv
// Behavioural external crystal or clock source for the timer's counting input
`timescale 1ns/1ps
module s16t_osc_model #(
  parameter int HALF_NS = 2500
) (
  input wire logic start_i,
  input wire logic [7:0] edges_i,
  output logic clk_o,
  output logic busy_o
);
  // ==========================================
  // Burst of rising edges, idle low between bursts
  initial begin
    clk_o = 1'b0;
    busy_o = 1'b0;
  end
  always @(posedge start_i) begin
    busy_o = 1'b1;
    repeat (edges_i) begin
      #HALF_NS clk_o = 1'b1;
      #HALF_NS clk_o = 1'b0;
    end
    busy_o = 1'b0;
  end
endmodule : s16t_osc_model

// ### sim/s16t_timer_bench.sv
// Self-checking bench for the sixteen-bit timer
`timescale 1ns/1ps
module s16t_timer_bench;
  logic clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
  logic sleep_i = 1'b0, adc_enable_i = 1'b0, osc_start = 1'b0;
  logic [31:0] adr_i = 32'h0000_0000, dat_i = 32'h0000_0000, dat_o;
  logic [3:0] sel_i = 4'h0, compare_mode_field_i = 4'h0;
  logic [1:0] port_out_i = 2'h2, port_direction_bits_i = 2'h1, shared_port_pin_o, shared_port_pin_oe_o;
  logic [15:0] compare_register_pair_i = 16'h0010;
  logic [7:0] osc_edges = 8'h08;
  logic ack_o, osc_enable_bit_o, irq_o, special_event_o, adc_start_o, osc_clk, osc_busy;
  int fail_count = 0, samples_checked = 0, cycles = 0;

  always #5 clk_i = ~clk_i;

  s16t_osc_model s16t_osc_model_i (.start_i(osc_start), .edges_i(osc_edges), .clk_o(osc_clk), .busy_o(osc_busy));
  s16t_timer s16t_timer_i (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
    .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .shared_port_pin_zero_i(osc_clk), .osc_clk_i(osc_clk), .port_out_i(port_out_i),
    .port_direction_bits_i(port_direction_bits_i), .sleep_i(sleep_i),
    .compare_mode_field_i(compare_mode_field_i), .compare_register_pair_i(compare_register_pair_i),
    .adc_enable_i(adc_enable_i), .shared_port_pin_o(shared_port_pin_o),
    .shared_port_pin_oe_o(shared_port_pin_oe_o), .osc_enable_bit_o(osc_enable_bit_o), .irq_o(irq_o),
    .special_event_o(special_event_o), .adc_start_o(adc_start_o));

  // ==========================================
  // Bus cycles and comparisons
  task automatic wb_cycle(input logic [7:0] idx, input logic wr, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= wr;
    sel_i <= 4'hF;
    adr_i <= {22'h00_0000, idx, 2'h0};
    dat_i <= {24'h00_0000, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb_cycle
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb_cycle(idx, 1'b1, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] idx, output logic [7:0] q);
    wb_cycle(idx, 1'b0, 8'h00, q);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic check_eq(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_eq
  task automatic check_range(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    samples_checked++;
    if (!(got >= lo && got <= hi) || $isunknown(got)) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask : check_range
  task automatic read_count(output logic [15:0] c);
    rd(s16t_pkg::IDX_COUNT_LOW, c[7:0]);
    rd(s16t_pkg::IDX_COUNT_HIGH, c[15:8]);
  endtask : read_count
  task automatic set_count(input logic [15:0] c);
    wr(s16t_pkg::IDX_COUNT_HIGH, c[15:8]);
    wr(s16t_pkg::IDX_COUNT_LOW, c[7:0]);
  endtask : set_count

  // ==========================================
  // Scenarios
  task automatic t_registers();
    logic [7:0] q;
    rd(s16t_pkg::IDX_TIMER_CONTROL, q); check_eq(q, 16'h0000);
    rd(s16t_pkg::IDX_INT_FLAGS, q); check_eq(q, 16'h0000);
    rd(s16t_pkg::IDX_INT_ENABLES, q); check_eq(q, 16'h0000);
    rd(8'h01, q); check_eq(q, 16'h0000);
    wr(s16t_pkg::IDX_TIMER_CONTROL, 8'hF6);
    rd(s16t_pkg::IDX_TIMER_CONTROL, q); check_eq(q, 16'h0036);
    wr(s16t_pkg::IDX_TIMER_CONTROL, 8'h00);
  endtask : t_registers
  task automatic t_osc_pins();
    wr(s16t_pkg::IDX_TIMER_CONTROL, 8'h08);
    tick(2);
    check_eq(osc_enable_bit_o, 16'h0001);
    check_eq(shared_port_pin_oe_o, 16'h0000);
    wr(s16t_pkg::IDX_TIMER_CONTROL, 8'h00);
    tick(2);
    check_eq(osc_enable_bit_o, 16'h0000);
    check_eq({shared_port_pin_oe_o, shared_port_pin_o}, 16'h000A);
  endtask : t_osc_pins
  task automatic t_overflow();
    logic [7:0] q;
    logic [15:0] c;
    q = 8'h00;
    set_count(16'hFFFE);
    wr(s16t_pkg::IDX_GLOBAL_INT, 8'hC0);
    wr(s16t_pkg::IDX_TIMER_CONTROL, 8'h01);
    for (int k = 0; k < 20 && q[0] !== 1'b1; k++) rd(s16t_pkg::IDX_INT_FLAGS, q);
    check_eq(q, 16'h0001);
    read_count(c); check_range(c, 16'h0000, 16'h0010);
    check_eq(irq_o, 16'h0000);
    wr(s16t_pkg::IDX_INT_ENABLES, 8'h01);
    tick(2); check_eq(irq_o, 16'h0001);
    wr(s16t_pkg::IDX_INT_FLAGS, 8'h00);
    tick(2); check_eq(irq_o, 16'h0000);
    wr(s16t_pkg::IDX_TIMER_CONTROL, 8'h00);
  endtask : t_overflow
  task automatic t_prescale();
    logic [7:0] q;
    int e;
    for (int ps = 0; ps < 4; ps++) begin
      set_count(16'h0000);
      wr(s16t_pkg::IDX_TIMER_CONTROL, 8'h01 | 8'(ps << 4));
      repeat (256) @(posedge clk_i);
      wr(s16t_pkg::IDX_TIMER_CONTROL, 8'h00);
      rd(s16t_pkg::IDX_COUNT_LOW, q);
      e = 256 / (4 << ps);
      check_range(q, 16'(e - 1), 16'(e + 2));
    end
  endtask : t_prescale
  task automatic wait_event(output int n);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (special_event_o !== 1'b1 && n < 300);
  endtask : wait_event
  task automatic t_special();
    logic [7:0] q;
    int n;
    set_count(16'h0000);
    @(posedge clk_i);
    compare_mode_field_i <= s16t_pkg::MODE_SPECIAL_EVENT;
    adc_enable_i <= 1'b1;
    wr(s16t_pkg::IDX_TIMER_CONTROL, 8'h01);
    wait_event(n);
    check_eq(adc_start_o, 16'h0001);
    wait_event(n);
    check_range(16'(n), 16'h003E, 16'h0044);
    wr(s16t_pkg::IDX_TIMER_CONTROL, 8'h00);
    compare_mode_field_i <= 4'h0;
    rd(s16t_pkg::IDX_INT_FLAGS, q); check_eq(q, 16'h0000);
  endtask : t_special
  task automatic ext_burst(input logic [7:0] ctl, input logic slp, input logic [3:0] mode, input logic [15:0] exp);
    logic [15:0] c;
    set_count(16'h0000);
    compare_mode_field_i <= mode;
    wr(s16t_pkg::IDX_TIMER_CONTROL, 8'h08);
    tick(20);
    wr(s16t_pkg::IDX_TIMER_CONTROL, ctl);
    sleep_i <= slp;
    osc_start <= 1'b1;
    tick(2);
    osc_start <= 1'b0;
    while (osc_busy === 1'b1) tick(1);
    tick(20);
    sleep_i <= 1'b0;
    compare_mode_field_i <= 4'h0;
    wr(s16t_pkg::IDX_TIMER_CONTROL, 8'h00);
    read_count(c); check_eq(c, exp);
  endtask : ext_burst
  task automatic t_external();
    ext_burst(8'h0B, 1'b0, 4'h0, 16'h0008);
    compare_register_pair_i <= 16'h0004;
    ext_burst(8'h0F, 1'b1, s16t_pkg::MODE_SPECIAL_EVENT, 16'h0008);
    compare_register_pair_i <= 16'h0010;
    ext_burst(8'h0B, 1'b1, 4'h0, 16'h0000);
  endtask : t_external

  // ==========================================
  // Sequence, timeout and verdict
  task automatic report_and_stop();
    $display("Mismatches %0d, comparisons %0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_registers();
    t_osc_pins();
    t_overflow();
    t_prescale();
    t_special();
    t_external();
    report_and_stop();
  end
endmodule : s16t_timer_bench
